//--- hdl/fsl_pkg.sv
// constants shared by the flash status, lockdown and suspend host controller
package fsl_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int REG_AW = 4;
	localparam int CLK_NS = 8;

	// software operation codes written to the command register
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROG = 4'h1;
	localparam logic [3:0] OP_SERASE = 4'h2;
	localparam logic [3:0] OP_CERASE = 4'h3;
	localparam logic [3:0] OP_LOCKDN = 4'h4;
	localparam logic [3:0] OP_SUSP = 4'h5;
	localparam logic [3:0] OP_RESUME = 4'h6;
	localparam logic [3:0] OP_IDEXIT = 4'h7;
	localparam logic [3:0] OP_LOCKQ = 4'h8;
	localparam logic [3:0] OP_HBQ = 4'h9;
	localparam logic [3:0] OP_LOCKB = 4'hA;
	localparam logic [3:0] OP_CFG = 4'hB;
	localparam logic [3:0] OP_PPR = 4'hC;
	localparam logic [3:0] OP_IDENT = 4'hD;

	// flash command bytes and command addresses
	localparam logic [7:0] C_UNLK1 = 8'hAA;
	localparam logic [7:0] C_UNLK2 = 8'h55;
	localparam logic [7:0] C_ERSETUP = 8'h80;
	localparam logic [7:0] C_PROG = 8'hA0;
	localparam logic [7:0] C_CERASE = 8'h10;
	localparam logic [7:0] C_SERASE = 8'h30;
	localparam logic [7:0] C_LOCKDN = 8'h60;
	localparam logic [7:0] C_SUSP = 8'hB0;
	localparam logic [7:0] C_RESUME = 8'h30;
	localparam logic [7:0] C_IDEXIT = 8'hF0;
	localparam logic [7:0] C_IDENT = 8'h90;
	localparam logic [7:0] C_PREG = 8'hC0;
	localparam logic [7:0] C_CFG = 8'hD0;
	localparam logic [11:0] A_CMD1 = 12'h555;
	localparam logic [11:0] A_CMD2 = 12'hAAA;
	localparam logic [11:0] A_HALF_B = 12'h080;
	localparam logic [1:0] LOCK_OFS = 2'h2;

	// status bit positions on the flash data lines
	localparam int DATA_POLL_BIT = 7;
	localparam int TOGGLE_STATUS_BIT = 6;
	localparam int OP_FAIL_BIT = 5;
	localparam int SUPPLY_LOW_BIT = 3;
	localparam int SECTOR_LOCK_FLAG = 0;
	localparam int HALF_B_LOCK_BIT = 1;

	// software register offsets and field positions
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_WDATA = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h5;
	localparam int S_BUSY = 0;
	localparam int S_DONE = 1;
	localparam int S_FAIL = 2;
	localparam int S_SUPPLY = 3;
	localparam int S_SUSP = 4;
	localparam int S_REJECT = 5;
	localparam int S_ERSUSP = 6;
	localparam int S_CFG = 7;
	localparam int CTRL_USE_PIN = 0;
	localparam int CTRL_FRESET = 1;

	// timing in nanoseconds and derived cycle counts (least times round up)
	localparam int SUSP_ERASE_NS = 15000;
	localparam int SUSP_PROG_NS = 20000;
	localparam int WE_PULSE_NS = 40;
	localparam int RD_ACCESS_NS = 70;
	localparam int FRESET_NS = 500;
	localparam int SUSP_ERASE_CYC = (SUSP_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSP_PROG_CYC = (SUSP_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRESET_CYC = (FRESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = 2;
	localparam int HOLD_CYC = 2;
	localparam int GAP_CYC = 2;
	localparam int SYNC_CYC = 2;
endpackage

//--- hdl/fsl_bus_cycle.sv
// one asynchronous flash bus cycle: a strobed write or a timed read
module fsl_bus_cycle (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic read_in,
	input wire logic [fsl_pkg::ADDR_W-1:0] addr_in,
	input wire logic [fsl_pkg::DATA_W-1:0] wdata_in,
	input wire logic [fsl_pkg::DATA_W-1:0] dq_in,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic [fsl_pkg::ADDR_W-1:0] addr_out,
	output logic [fsl_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic [fsl_pkg::DATA_W-1:0] rdata_out,
	output logic done_out
);
	typedef enum logic [5:0] {
		BC_IDLE = 6'b000001,
		BC_SETUP = 6'b000010,
		BC_PULSE = 6'b000100,
		BC_HOLD = 6'b001000,
		BC_READ = 6'b010000,
		BC_GAP = 6'b100000
	} fsl_bc_t;
	fsl_bc_t bc;
	logic [7:0] cnt;
	logic [fsl_pkg::DATA_W-1:0] dq_s1;
	logic [fsl_pkg::DATA_W-1:0] dq_s2;

	// data lines come from the flash pads, so they are synchronised first
	always_ff @(posedge clk_in) begin
		dq_s1 <= dq_in;
		dq_s2 <= dq_s1;
	end

	// strobe sequencing; output enable never falls during a write
	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		if (!rstn_in) begin
			bc <= BC_IDLE;
			cnt <= 8'h00;
			ce_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			we_n_out <= 1'b1;
			dq_oe_out <= 1'b0;
			addr_out <= '0;
			dq_out <= '0;
			rdata_out <= '0;
		end else begin
			if (cnt != 8'h00) cnt <= cnt - 8'h01;
			unique case (bc)
				BC_IDLE: begin
					if (start_in) begin
						addr_out <= addr_in;
						dq_out <= wdata_in;
						ce_n_out <= 1'b0;
						if (read_in) begin
							oe_n_out <= 1'b0;
							bc <= BC_READ;
							cnt <= 8'(fsl_pkg::RD_ACCESS_CYC + fsl_pkg::SYNC_CYC);
						end else begin
							dq_oe_out <= 1'b1;
							bc <= BC_SETUP;
							cnt <= 8'(fsl_pkg::SETUP_CYC);
						end
					end
				end
				BC_SETUP: if (cnt == 8'h00) begin
					we_n_out <= 1'b0;
					bc <= BC_PULSE;
					cnt <= 8'(fsl_pkg::WE_PULSE_CYC);
				end
				BC_PULSE: if (cnt == 8'h00) begin
					we_n_out <= 1'b1; // data latched on this rising edge
					bc <= BC_HOLD;
					cnt <= 8'(fsl_pkg::HOLD_CYC);
				end
				BC_HOLD: if (cnt == 8'h00) begin
					ce_n_out <= 1'b1;
					dq_oe_out <= 1'b0;
					bc <= BC_GAP;
					cnt <= 8'(fsl_pkg::GAP_CYC);
				end
				BC_READ: if (cnt == 8'h00) begin
					rdata_out <= dq_s2;
					ce_n_out <= 1'b1;
					oe_n_out <= 1'b1;
					bc <= BC_GAP;
					cnt <= 8'(fsl_pkg::GAP_CYC);
				end
				BC_GAP: if (cnt == 8'h00) begin
					done_out <= 1'b1;
					bc <= BC_IDLE;
				end
			endcase
		end
	end

	// write strobe low only with output enable high and chip select low
	a_write_inhibit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!we_n_out |-> (oe_n_out && !ce_n_out && dq_oe_out))
		else $error("write strobe active with output enable low");
endmodule

//--- hdl/fsl_host.sv
// host controller that drives the flash pins for status, lockdown and suspend
//
// The register offsets and the strobed register port were decided locally.
module fsl_host #(
	parameter int SUSP_E_CYC = fsl_pkg::SUSP_ERASE_CYC,
	parameter int SUSP_P_CYC = fsl_pkg::SUSP_PROG_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [fsl_pkg::REG_AW-1:0] sw_addr_in,
	input wire logic [31:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [31:0] sw_rdata_out,
	output logic flash_ce_n_out,
	output logic flash_oe_n_out,
	output logic flash_we_n_out,
	output logic [fsl_pkg::ADDR_W-1:0] flash_addr_out,
	output logic [fsl_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_out,
	input wire logic [fsl_pkg::DATA_W-1:0] flash_dq_in,
	input wire logic flash_rdy_in,
	output logic flash_reset_n_out
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ISSUE = 7'b0000010,
		ST_WAITB = 7'b0000100,
		ST_POLL = 7'b0001000,
		ST_SUSPW = 7'b0010000,
		ST_EXIT = 7'b0100000,
		ST_FIN = 7'b1000000
	} fsl_st_t;
	typedef enum logic [3:0] {
		WK_STEP = 4'b0001,
		WK_POLL1 = 4'b0010,
		WK_POLL2 = 4'b0100,
		WK_EXIT = 4'b1000
	} fsl_wk_t;

	fsl_st_t st;
	fsl_wk_t wk;
	logic [3:0] op_q;
	logic [2:0] step;
	logic [fsl_pkg::ADDR_W-1:0] addr_q;
	logic [fsl_pkg::ADDR_W-1:0] resume_addr;
	logic [fsl_pkg::DATA_W-1:0] wdata_q;
	logic [fsl_pkg::DATA_W-1:0] rdata_q;
	logic [fsl_pkg::DATA_W-1:0] r1;
	logic cfg01, use_pin, done_f, fail_f, supply_f, reject_f;
	logic suspended, susp_erase, susp_pend, err_seen;
	logic [15:0] wait_cnt;
	logic [7:0] rst_cnt;
	logic rdy_s1, rdy_s2;
	logic bus_start, bus_read, bus_done;
	logic [fsl_pkg::ADDR_W-1:0] bus_addr;
	logic [fsl_pkg::DATA_W-1:0] bus_wdata, bus_rdata;
	logic [37:0] word;
	logic cmd_wr, start_ok, toggling, poll_err, last_step, poll_fin, fin_err;

	// operations that end with a busy internal cycle and need polling
	function automatic logic fsl_polled(input logic [3:0] op);
		fsl_polled = (op == fsl_pkg::OP_PROG) || (op == fsl_pkg::OP_SERASE) ||
			(op == fsl_pkg::OP_CERASE) || (op == fsl_pkg::OP_RESUME) ||
			(op == fsl_pkg::OP_LOCKB) || (op == fsl_pkg::OP_PPR);
	endfunction

	// number of bus cycles minus one for each operation
	function automatic logic [2:0] fsl_last(input logic [3:0] op);
		unique case (op)
			fsl_pkg::OP_READ, fsl_pkg::OP_SUSP, fsl_pkg::OP_RESUME,
			fsl_pkg::OP_IDEXIT: fsl_last = 3'h0;
			fsl_pkg::OP_SERASE, fsl_pkg::OP_CERASE, fsl_pkg::OP_LOCKDN: fsl_last = 3'h5;
			default: fsl_last = 3'h3;
		endcase
	endfunction

	// bus word for one step: {is_read, address, data}
	function automatic logic [37:0] fsl_word(input logic [3:0] op, input logic [2:0] s,
			input logic [fsl_pkg::ADDR_W-1:0] a, input logic [fsl_pkg::DATA_W-1:0] d);
		logic [7:0] third;
		third = fsl_pkg::C_ERSETUP;
		unique case (op)
			fsl_pkg::OP_PROG: third = fsl_pkg::C_PROG;
			fsl_pkg::OP_LOCKQ, fsl_pkg::OP_HBQ, fsl_pkg::OP_IDENT: third = fsl_pkg::C_IDENT;
			fsl_pkg::OP_LOCKB, fsl_pkg::OP_PPR: third = fsl_pkg::C_PREG;
			fsl_pkg::OP_CFG: third = fsl_pkg::C_CFG;
			default: third = fsl_pkg::C_ERSETUP;
		endcase
		fsl_word = {1'b0, 9'h000, fsl_pkg::A_CMD1, 8'h00, fsl_pkg::C_UNLK1};
		if (op == fsl_pkg::OP_READ) fsl_word = {1'b1, a, d};
		else if (op == fsl_pkg::OP_SUSP) fsl_word = {1'b0, 21'h000000, 8'h00, fsl_pkg::C_SUSP};
		else if (op == fsl_pkg::OP_RESUME) fsl_word = {1'b0, 21'h000000, 8'h00, fsl_pkg::C_RESUME};
		else if (op == fsl_pkg::OP_IDEXIT) fsl_word = {1'b0, 21'h000000, 8'h00, fsl_pkg::C_IDEXIT};
		else if (s == 3'h1 || s == 3'h4) fsl_word = {1'b0, 9'h000, fsl_pkg::A_CMD2, 8'h00, fsl_pkg::C_UNLK2};
		else if (s == 3'h2) fsl_word = {1'b0, 9'h000, fsl_pkg::A_CMD1, 8'h00, third};
		else if (s == 3'h5) begin
			unique case (op)
				fsl_pkg::OP_SERASE: fsl_word = {1'b0, a, 8'h00, fsl_pkg::C_SERASE};
				fsl_pkg::OP_LOCKDN: fsl_word = {1'b0, a, 8'h00, fsl_pkg::C_LOCKDN};
				default: fsl_word = {1'b0, 9'h000, fsl_pkg::A_CMD1, 8'h00, fsl_pkg::C_CERASE};
			endcase
		end else if (s == 3'h3 && fsl_last(op) == 3'h3) begin
			unique case (op)
				fsl_pkg::OP_LOCKQ: fsl_word = {1'b1, a[20:2], fsl_pkg::LOCK_OFS, d};
				fsl_pkg::OP_HBQ: fsl_word = {1'b1, 9'h000, fsl_pkg::A_HALF_B, d};
				fsl_pkg::OP_IDENT: fsl_word = {1'b1, a, d};
				fsl_pkg::OP_LOCKB: fsl_word = {1'b0, 9'h000, fsl_pkg::A_HALF_B,
					d & ~(16'h0001 << fsl_pkg::HALF_B_LOCK_BIT)};
				fsl_pkg::OP_CFG: fsl_word = {1'b0, 21'h000000, 15'h0000, d[0]};
				default: fsl_word = {1'b0, a, d};
			endcase
		end
	endfunction

	assign cmd_wr = sw_wr_in && (sw_addr_in == fsl_pkg::REG_CMD);
	assign start_ok = cmd_wr && (st == ST_IDLE) && (rst_cnt == 8'h00);
	assign word = fsl_word(op_q, step, addr_q, wdata_q);
	assign last_step = (step == fsl_last(op_q));
	assign toggling = r1[fsl_pkg::TOGGLE_STATUS_BIT] ^ bus_rdata[fsl_pkg::TOGGLE_STATUS_BIT];
	// error bits count only when both reads of a pair show them: a pair that
	// spans completion ends on array data, whose bits 5 and 3 mean nothing
	assign poll_err = (r1[fsl_pkg::OP_FAIL_BIT] & bus_rdata[fsl_pkg::OP_FAIL_BIT]) |
		(r1[fsl_pkg::SUPPLY_LOW_BIT] & bus_rdata[fsl_pkg::SUPPLY_LOW_BIT]);
	assign poll_fin = (st == ST_WAITB) && bus_done && (wk == WK_POLL2) &&
		(!toggling || (poll_err && err_seen));
	assign fin_err = toggling || err_seen;

	// bus request: command step, status poll read, or identification exit
	always_comb begin
		bus_start = (st == ST_ISSUE) || (st == ST_EXIT) ||
			((st == ST_POLL) && !susp_pend && (!use_pin || rdy_s2));
		bus_read = 1'b1;
		bus_addr = addr_q;
		bus_wdata = '0;
		if (st == ST_ISSUE) begin
			bus_read = word[37];
			bus_addr = word[36:16];
			bus_wdata = word[15:0];
		end else if (st == ST_EXIT) begin
			bus_read = 1'b0;
			bus_addr = '0;
			bus_wdata = {8'h00, fsl_pkg::C_IDEXIT};
		end
	end

	fsl_bus_cycle u_bus (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.start_in(bus_start),
		.read_in(bus_read),
		.addr_in(bus_addr),
		.wdata_in(bus_wdata),
		.dq_in(flash_dq_in),
		.ce_n_out(flash_ce_n_out),
		.oe_n_out(flash_oe_n_out),
		.we_n_out(flash_we_n_out),
		.addr_out(flash_addr_out),
		.dq_out(flash_dq_out),
		.dq_oe_out(flash_dq_oe_out),
		.rdata_out(bus_rdata),
		.done_out(bus_done)
	);

	// ready pin comes from outside; two flops before anything looks at it
	always_ff @(posedge clk_in) begin
		rdy_s1 <= flash_rdy_in;
		rdy_s2 <= rdy_s1;
	end

	// flash reset pulse after our reset or on request; the only lock clear
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rst_cnt <= 8'(fsl_pkg::FRESET_CYC);
			flash_reset_n_out <= 1'b0;
		end else begin
			if (sw_wr_in && sw_addr_in == fsl_pkg::REG_CTRL && st == ST_IDLE &&
					sw_wdata_in[fsl_pkg::CTRL_FRESET]) rst_cnt <= 8'(fsl_pkg::FRESET_CYC);
			else if (rst_cnt != 8'h00) rst_cnt <= rst_cnt - 8'h01;
			flash_reset_n_out <= (rst_cnt == 8'h00);
		end
	end

	// sequencer
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st <= ST_IDLE;
			wk <= WK_STEP;
			op_q <= fsl_pkg::OP_READ;
			step <= 3'h0;
			addr_q <= '0;
			wdata_q <= '0;
			r1 <= '0;
			err_seen <= 1'b0;
			wait_cnt <= 16'h0000;
		end else begin
			if (wait_cnt != 16'h0000) wait_cnt <= wait_cnt - 16'h0001;
			unique case (st)
				ST_IDLE: if (start_ok && !reject_next()) begin
					op_q <= sw_wdata_in[3:0];
					step <= 3'h0;
					err_seen <= 1'b0;
					addr_q <= (sw_wdata_in[3:0] == fsl_pkg::OP_RESUME) ? resume_addr : addr_q;
					st <= ST_ISSUE;
				end
				ST_ISSUE: begin
					wk <= WK_STEP;
					st <= ST_WAITB;
				end
				ST_POLL: if (susp_pend) begin
					op_q <= fsl_pkg::OP_SUSP;
					step <= 3'h0;
					st <= ST_ISSUE;
				end else if (bus_start) begin
					st <= ST_WAITB;
				end
				ST_SUSPW: if (wait_cnt == 16'h0000) st <= ST_FIN;
				ST_EXIT: begin
					wk <= WK_EXIT;
					st <= ST_WAITB;
				end
				ST_FIN: st <= ST_IDLE;
				ST_WAITB: if (bus_done) begin
					unique case (wk)
						WK_STEP: if (!last_step) begin
							step <= step + 3'h1;
							st <= ST_ISSUE;
						end else if (fsl_polled(op_q)) begin
							wk <= WK_POLL1;
							st <= ST_POLL;
						end else if (op_q == fsl_pkg::OP_SUSP) begin
							wait_cnt <= susp_erase ? 16'(SUSP_E_CYC) : 16'(SUSP_P_CYC);
							st <= ST_SUSPW;
						end else if (op_q == fsl_pkg::OP_LOCKQ || op_q == fsl_pkg::OP_HBQ ||
								op_q == fsl_pkg::OP_IDENT) begin
							st <= ST_EXIT;
						end else begin
							st <= ST_FIN;
						end
						WK_POLL1: begin
							r1 <= bus_rdata;
							wk <= WK_POLL2;
							st <= ST_POLL;
						end
						WK_POLL2: if (!toggling || (poll_err && err_seen)) begin
							st <= (fin_err || cfg01) ? ST_EXIT : ST_FIN;
						end else begin
							err_seen <= err_seen | poll_err;
							wk <= WK_POLL1;
							st <= ST_POLL;
						end
						WK_EXIT: st <= ST_FIN;
					endcase
				end
			endcase
			if (st == ST_IDLE && sw_wr_in && sw_addr_in == fsl_pkg::REG_ADDR)
				addr_q <= sw_wdata_in[fsl_pkg::ADDR_W-1:0];
			if (st == ST_IDLE && sw_wr_in && sw_addr_in == fsl_pkg::REG_WDATA)
				wdata_q <= sw_wdata_in[fsl_pkg::DATA_W-1:0];
		end
	end

	// undefined command codes, and commands the device would not accept in the present suspend state
	function automatic logic reject_next();
		logic [3:0] op;
		op = sw_wdata_in[3:0];
		reject_next = (op > fsl_pkg::OP_IDENT) || (op == fsl_pkg::OP_SUSP) ||
			((op == fsl_pkg::OP_RESUME) && !suspended) ||
			(suspended && (op == fsl_pkg::OP_SERASE || op == fsl_pkg::OP_CERASE)) ||
			(suspended && !susp_erase && op != fsl_pkg::OP_READ &&
				op != fsl_pkg::OP_RESUME && op != fsl_pkg::OP_IDEXIT);
	endfunction

	// suspend bookkeeping: a suspend order is taken while a poll is in progress
	always_ff @(posedge clk_in) begin
		if (!rstn_in || rst_cnt != 8'h00) begin
			suspended <= 1'b0;
			susp_erase <= 1'b0;
			susp_pend <= 1'b0;
			resume_addr <= '0;
		end else begin
			if (cmd_wr && sw_wdata_in[3:0] == fsl_pkg::OP_SUSP && !suspended &&
					(st == ST_POLL || st == ST_WAITB) && wk != WK_STEP && wk != WK_EXIT) begin
				susp_pend <= 1'b1;
				susp_erase <= (op_q == fsl_pkg::OP_RESUME) ? susp_erase :
					(op_q == fsl_pkg::OP_SERASE || op_q == fsl_pkg::OP_CERASE);
				resume_addr <= addr_q;
			end else if (st == ST_POLL || st == ST_FIN) begin // a poll that ends first drops it
				susp_pend <= 1'b0;
			end
			if (st == ST_SUSPW && wait_cnt == 16'h0000) suspended <= 1'b1;
			else if (st == ST_ISSUE && op_q == fsl_pkg::OP_RESUME) suspended <= 1'b0;
		end
	end

	// result flags, config shadow and read data
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cfg01 <= 1'b0;
			use_pin <= 1'b0;
			done_f <= 1'b0;
			fail_f <= 1'b0;
			supply_f <= 1'b0;
			reject_f <= 1'b0;
			rdata_q <= '0;
		end else begin
			if (sw_wr_in && sw_addr_in == fsl_pkg::REG_CTRL)
				use_pin <= sw_wdata_in[fsl_pkg::CTRL_USE_PIN];
			if (start_ok) begin
				done_f <= 1'b0;
				fail_f <= 1'b0;
				supply_f <= 1'b0;
				reject_f <= reject_next();
			end
			if (st == ST_FIN) done_f <= 1'b1;
			if (poll_fin && fin_err) begin
				fail_f <= 1'b1;
				supply_f <= bus_rdata[fsl_pkg::SUPPLY_LOW_BIT];
			end
			if (st == ST_WAITB && bus_done && (wk == WK_POLL2 || (wk == WK_STEP && word[37])))
				rdata_q <= bus_rdata;
			if (st == ST_WAITB && bus_done && wk == WK_STEP && op_q == fsl_pkg::OP_CFG)
				cfg01 <= wdata_q[0];
		end
	end

	// software read port: data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sw_rdata_out <= 32'h00000000;
		end else if (sw_rd_in) begin
			unique case (sw_addr_in)
				fsl_pkg::REG_ADDR: sw_rdata_out <= {11'h000, addr_q};
				fsl_pkg::REG_WDATA: sw_rdata_out <= {16'h0000, wdata_q};
				fsl_pkg::REG_RDATA: sw_rdata_out <= {16'h0000, rdata_q};
				fsl_pkg::REG_STATUS: sw_rdata_out <= {24'h000000, cfg01, susp_erase & suspended,
					reject_f, suspended, supply_f, fail_f, done_f,
					(st != ST_IDLE) || (rst_cnt != 8'h00)};
				fsl_pkg::REG_CTRL: sw_rdata_out <= {31'h00000000, use_pin};
				default: sw_rdata_out <= 32'h00000000;
			endcase
		end else begin
			sw_rdata_out <= 32'h00000000;
		end
	end

	sequence s_exit_issued;
		(st == ST_EXIT) ##1 (st == ST_WAITB && wk == WK_EXIT);
	endsequence

	a_fail_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		poll_fin && fin_err |=> s_exit_issued)
		else $error("failed operation not followed by identification exit");
	a_supply_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		poll_fin && bus_rdata[fsl_pkg::SUPPLY_LOW_BIT] && toggling |=> s_exit_issued ##1 fail_f)
		else $error("supply low not reported or exit missing");
	a_erase_refused: assert property (@(posedge clk_in) disable iff (!rstn_in)
		start_ok && suspended && sw_wdata_in[3:0] == fsl_pkg::OP_SERASE |=> st == ST_IDLE && reject_f)
		else $error("sector erase issued while suspended");
	a_susp_wait: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(st == ST_SUSPW) |-> (st == ST_SUSPW) [*8])
		else $error("suspend wait cut short");
	a_halfb_bit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		op_q == fsl_pkg::OP_LOCKB && step == 3'h3 && !flash_we_n_out |->
			!flash_dq_out[fsl_pkg::HALF_B_LOCK_BIT])
		else $error("half-B lock sent with bit 1 set");
	a_query_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st == ST_WAITB && bus_done && wk == WK_STEP && last_step && op_q == fsl_pkg::OP_HBQ
			|=> s_exit_issued)
		else $error("protection status read without exit");
	a_recheck: assert property (@(posedge clk_in) disable iff (!rstn_in)
		st == ST_WAITB && bus_done && wk == WK_POLL2 && toggling && poll_err && !err_seen
			|=> st == ST_POLL && wk == WK_POLL1 && err_seen && !fail_f)
		else $error("first failure seen without a re-read");
	a_cfg_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
		poll_fin && !fin_err && !cfg01 |=> st == ST_FIN ##1 st == ST_IDLE && done_f)
		else $error("config 00 success did not finish directly");
endmodule

//--- verification/fsl_flash_model.sv
// behavioural flash die answering status, lockdown and suspend commands
module fsl_flash_model (
	input wire logic rst_n_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic [20:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic rdy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lk [64];
	logic [7:0] c3, d;
	logic tog, fail, idm, susp, hb, pg, ld7, hold;
	// status configuration is 00 at power-up; the reset pin leaves it alone
	logic cfg = 1'b0;
	int n, left;
	// internal cycle counts down in 100 ns steps; suspend freezes it
	assign rdy_out = !(left > 0 && !susp);
	always #100 if (left > 0 && !susp) left--;
	// released bus shows a moving pattern, never the last value
	always_comb
		if (ce_n_in || oe_n_in) dq_out = 16'hA5C3 ^ {16{tog}};
		else if (!rdy_out || fail || hold)
			dq_out = {8'h0, (cfg ? rdy_out : pg && !ld7), tog, fail, 5'h0};
		else if (idm) dq_out = {14'h0, addr_in[11:0] == 12'h080 && !hb,
			lk[addr_in[20:15]] && addr_in[1:0] == 2'h2};
		else dq_out = ~addr_in[15:0];
	always @(negedge oe_n_in) if (!rdy_out && !ce_n_in) tog = !tog;
	always @(negedge rst_n_in) begin
		foreach (lk[i]) lk[i] = 1'b0;
		n = 0;
		left = 0;
		{tog, fail, idm, susp, hb, pg, hold} = 7'h00;
	end
	// commands latch on the rising write strobe only while selected
	always @(posedge we_n_in) if (!ce_n_in && oe_n_in && rst_n_in) begin
		d = dq_in[7:0];
		if (left > 0 && !susp && d == 8'hB0) susp = 1;
		else if (susp && n == 0 && d == 8'h30) susp = 0;
		else if (n == 0 && d == 8'hF0) begin
			if (fail) left = 0;
			fail = 0;
			idm = 0;
			hold = 0;
		end else if (n < 2) n++;
		else if (n == 2) begin
			c3 = d;
			n = (d == 8'h90) ? 0 : 3;
			idm |= d == 8'h90;
		end else if (c3 == 8'h80 && n < 5) n++;
		else begin
			n = 0;
			if ((c3 == 8'hA0 || d == 8'h30) && lk[addr_in[20:15]]) begin
				fail = 1;
				left = 10;
			end else if (c3 == 8'hA0) begin
				left = 50;
				pg = 1;
				ld7 = dq_in[7];
				hold = cfg;
			end else if (d == 8'h30 || d == 8'h10) begin
				left = 200;
				pg = 0;
				hold = cfg;
			end else if (d == 8'h60) lk[addr_in[20:15]] = 1;
			else if (c3 == 8'hC0 && addr_in[11:0] == 12'h080) hb = !dq_in[1];
			else if (c3 == 8'hD0) cfg = dq_in[0];
		end
	end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the flash host controller against a die model
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rstn_in = 0, sw_wr_in = 0, sw_rd_in = 0;
	logic [3:0] sw_addr_in = 4'h0;
	logic [31:0] sw_wdata_in = 32'h0, sw_rdata_out, v;
	logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_dq_oe_out;
	logic flash_rdy_in, flash_reset_n_out;
	logic [20:0] flash_addr_out;
	logic [15:0] flash_dq_out, fdq;
	wire logic [15:0] flash_dq_in = flash_dq_oe_out ? flash_dq_out : fdq;
	int error_cnt = 0, n_compared = 0;
	initial forever #4 clk_in = !clk_in;
	fsl_host #(.SUSP_E_CYC(20), .SUSP_P_CYC(20)) fsl_host_i (.clk_in, .rstn_in, .sw_addr_in,
		.sw_wdata_in, .sw_wr_in, .sw_rd_in, .sw_rdata_out, .flash_ce_n_out, .flash_oe_n_out,
		.flash_we_n_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_dq_in,
		.flash_rdy_in, .flash_reset_n_out);
	fsl_flash_model fsl_flash_model_i (.rst_n_in(flash_reset_n_out), .ce_n_in(flash_ce_n_out),
		.oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .addr_in(flash_addr_out),
		.dq_in(flash_dq_in), .dq_out(fdq), .rdy_out(flash_rdy_in));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		sw_addr_in <= a;
		sw_wdata_in <= d;
		sw_wr_in <= 1'b1;
		@(posedge clk_in);
		sw_wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		sw_addr_in <= a;
		sw_rd_in <= 1'b1;
		@(posedge clk_in);
		sw_rd_in <= 1'b0;
		#1 v = sw_rdata_out;
	endtask
	task automatic idle;
		do rd(4'h4); while (v[0] !== 1'b0);
	endtask
	task automatic go(input logic [3:0] op, input logic [20:0] a);
		wr(4'h1, {11'h0, a});
		wr(4'h0, {28'h0, op});
		idle();
	endtask
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		idle();
		go(4'h8, 21'h8000);
		rd(4'h3);
		chk("lock after reset", v[0], 1'b0);
		go(4'h1, 21'h8000);
		chk("program status", v[7:0], 8'h02);
		go(4'h4, 21'h8000);
		go(4'h8, 21'h8000);
		rd(4'h3);
		chk("lock flag", v[0], 1'b1);
		go(4'h1, 21'h8000);
		chk("locked program fail", v[2], 1'b1);
		wr(4'h1, 32'h10000);
		wr(4'h0, 32'h2);
		repeat (200) @(posedge clk_in);
		wr(4'h0, 32'h5);
		idle();
		chk("erase suspended", v[6:4], 3'h5);
		wr(4'h0, 32'h2);
		rd(4'h4);
		chk("erase refused", v[5], 1'b1);
		go(4'h6, 21'h0);
		chk("resumed", v[6:4], 3'h0);
		go(4'hA, 21'h80);
		go(4'h9, 21'h0);
		rd(4'h3);
		chk("half b locked", v[1], 1'b0);
		wr(4'h5, 32'h2);
		idle();
		go(4'h8, 21'h8000);
		rd(4'h3);
		chk("lock cleared", v[0], 1'b0);
		// config 01 with ready-pin polling: the exit must bring back array reads
		wr(4'h2, 32'h1);
		go(4'hB, 21'h0);
		wr(4'h5, 32'h1);
		go(4'h1, 21'h18000);
		chk("config 01 program", v[7:0], 8'h82);
		go(4'h0, 21'h18000);
		rd(4'h3);
		chk("read after exit", v[15:0], 16'h7FFF);
		wrap_up();
	end
endmodule
